// [logic/sibw_block_write.sv]
// Notes on behaviour
// - ack write address matching own address
// - ack index byte, load first location
// - ack byte count that follows index
// - store data bytes at consecutive locations
// - acknowledge each data byte within the count separately, refusing one that lands while the last is still crossing
// - slave address latched from select pin
// - interface runs only while reference clock runs
`timescale 1ns/10ps
`default_nettype none
module sibw_block_write (
  input  wire logic                             clock,
  input  wire logic                             rst_n,
  input  wire logic                             ce,
  input  wire logic                             ref_clk,
  input  wire logic                             scl,
  input  wire logic                             sda_i,
  output logic                                  sda_o,
  output logic                                  sda_oe,
  input  wire logic [1:0]                       address_select_pin,
  output logic [sibw_pkg::NUM_BYTES-1:0][7:0]   cfg_bytes,
  output logic                                  cfg_wr,
  output logic [7:0]                            cfg_wr_index
);
  sibw_pkg::sibw_link_s lq;
  sibw_pkg::sibw_link_s ld;
  sibw_pkg::sibw_sys_s  sq;
  sibw_pkg::sibw_sys_s  sd;
  logic scl_n;
  logic sda_n;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic byte_done;
  logic pending;
  logic req_edge;

  ////////////////////////////////////////////////////////////////////////
  // link side, clocked by the reference clock: frozen when it stops
  always_comb begin
    ld = lq;
    ld.scl_sy = {lq.scl_sy[1:0], scl};
    ld.sda_sy = {lq.sda_sy[1:0], sda_i};
    ld.sel_sy = {lq.sel_sy[1:0], address_select_pin};
    ld.ack_sy = {lq.ack_sy[1:0], sq.req_sy[sibw_pkg::SY_THIRD]};
    // a level counts once second and third stages agree
    scl_n = (lq.scl_sy[1] == lq.scl_sy[2]) ? lq.scl_sy[2] : lq.scl_f;
    sda_n = (lq.sda_sy[1] == lq.sda_sy[2]) ? lq.sda_sy[2] : lq.sda_f;
    ld.scl_f = scl_n;
    ld.sda_f = sda_n;
    scl_fall  = lq.scl_f & ~scl_n;
    start_c   = scl_n & lq.scl_f & lq.sda_f & ~sda_n;
    stop_c    = scl_n & lq.scl_f & ~lq.sda_f & sda_n;
    byte_done = scl_fall & (lq.bitcnt == sibw_pkg::BIT_LAST) & ~lq.in_ack;
    pending   = lq.req != lq.ack_sy[2];
    // strap caught once after reset release, never from software
    if (!lq.addr_ok && lq.sel_sy[1] == lq.sel_sy[2]) begin
      ld.addr    = 7'(sibw_pkg::ADDR_BASE + 7'(lq.sel_sy[2]));
      ld.addr_ok = 1'b1;
    end
    if (start_c) begin
      ld.state  = sibw_pkg::ST_ADDR;
      ld.bitcnt = sibw_pkg::BIT_FIRST;
      ld.in_ack = 1'b0;
      ld.drive  = 1'b0;
    end else if (stop_c) begin
      ld.state  = sibw_pkg::ST_IDLE;
      ld.in_ack = 1'b0;
      ld.drive  = 1'b0;
    end else if (lq.state != sibw_pkg::ST_IDLE) begin
      if (scl_n && !lq.scl_f && lq.bitcnt != sibw_pkg::BIT_LAST) begin
        ld.shreg  = {lq.shreg[6:0], sda_n};
        ld.bitcnt = 4'(lq.bitcnt + 4'h1);
      end
      if (byte_done) begin
        ld.in_ack = 1'b1;
        case (lq.state)
          sibw_pkg::ST_ADDR: begin
            // read direction is not served here, so it drops out too
            if (lq.addr_ok && lq.shreg == {lq.addr, 1'b0}) begin
              ld.drive = 1'b1;
              ld.state = sibw_pkg::ST_INDEX;
            end else begin
              ld.state = sibw_pkg::ST_IGNORE;
            end
          end
          sibw_pkg::ST_INDEX: begin
            ld.drive = 1'b1;
            ld.idx   = lq.shreg;
            ld.state = sibw_pkg::ST_COUNT;
          end
          sibw_pkg::ST_COUNT: begin
            ld.drive = 1'b1;
            ld.cnt   = lq.shreg;
            ld.state = sibw_pkg::ST_DATA;
          end
          sibw_pkg::ST_DATA: begin
            // no stretching: a byte landing while the last is still crossing is refused
            if (lq.cnt != sibw_pkg::BYTE_ZERO && !pending) begin
              ld.drive   = 1'b1;
              ld.wr_idx  = lq.idx;
              ld.wr_data = lq.shreg;
              ld.req     = ~lq.req;
              ld.idx     = 8'(lq.idx + sibw_pkg::IDX_STEP);
              ld.cnt     = 8'(lq.cnt - sibw_pkg::IDX_STEP);
            end
          end
          default: begin
            ld.drive = 1'b0;
          end
        endcase
      end else if (scl_fall && lq.in_ack) begin
        ld.in_ack = 1'b0;
        ld.drive  = 1'b0;
        ld.bitcnt = sibw_pkg::BIT_FIRST;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lq <= '{scl_sy: 3'h7, sda_sy: 3'h7, sel_sy: sibw_pkg::SEL_SEED, scl_f: 1'b1, sda_f: 1'b1,
              state: sibw_pkg::ST_IDLE, shreg: sibw_pkg::BYTE_ZERO,
              bitcnt: sibw_pkg::BIT_FIRST, in_ack: 1'b0, drive: 1'b0,
              idx: sibw_pkg::BYTE_ZERO, cnt: sibw_pkg::BYTE_ZERO,
              addr: sibw_pkg::ADDR_ZERO, addr_ok: 1'b0, req: 1'b0,
              wr_idx: sibw_pkg::BYTE_ZERO, wr_data: sibw_pkg::BYTE_ZERO,
              ack_sy: sibw_pkg::SYNC_ZERO};
    end else begin
      lq <= ld;
    end
  end

  // open drain: only ever pull low
  assign sda_o  = 1'b0;
  assign sda_oe = lq.drive;

  ////////////////////////////////////////////////////////////////////////
  // system side: toggle crossing, byte array
  always_comb begin
    sd = sq;
    sd.wr = 1'b0;
    req_edge = sq.req_sy[sibw_pkg::SY_SECOND] != sq.req_sy[sibw_pkg::SY_THIRD];
    if (ce) begin
      sd.req_sy = {sq.req_sy[1:0], lq.req};
      // words stay still from toggle until its echo returns
      if (req_edge) begin
        sd.wr     = 1'b1;
        sd.wr_idx = lq.wr_idx;
        // out-of-range locations are acknowledged but dropped
        if (lq.wr_idx < 8'(sibw_pkg::NUM_BYTES)) begin
          sd.bytes[3'(lq.wr_idx)] = lq.wr_data;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sq <= '{req_sy: sibw_pkg::SYNC_ZERO, bytes: {sibw_pkg::NUM_BYTES{sibw_pkg::CFG_RESET}},
              wr: 1'b0, wr_idx: sibw_pkg::BYTE_ZERO};
    end else begin
      sq <= sd;
    end
  end

  assign cfg_bytes    = sq.bytes;
  assign cfg_wr       = sq.wr;
  assign cfg_wr_index = sq.wr_idx;

  ////////////////////////////////////////////////////////////////////////
  start_to_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    start_c |=> lq.state == sibw_pkg::ST_ADDR && !sda_oe)
    else $error("start did not enter address phase");

  addr_match_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    byte_done && lq.state == sibw_pkg::ST_ADDR && lq.addr_ok && lq.shreg == {lq.addr, 1'b0}
    |=> sda_oe && lq.state == sibw_pkg::ST_INDEX)
    else $error("matching address not acknowledged");

  addr_reject_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    byte_done && lq.state == sibw_pkg::ST_ADDR && lq.shreg != {lq.addr, 1'b0}
    |=> !sda_oe && lq.state == sibw_pkg::ST_IGNORE)
    else $error("foreign address acknowledged");

  ignore_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    lq.state == sibw_pkg::ST_IGNORE |-> !sda_oe && $stable(lq.req))
    else $error("ignored transfer touched the bus or wrote");

  index_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    byte_done && lq.state == sibw_pkg::ST_INDEX
    |=> lq.idx == $past(lq.shreg) && sda_oe && lq.state == sibw_pkg::ST_COUNT)
    else $error("index not loaded and acknowledged");

  count_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    byte_done && lq.state == sibw_pkg::ST_COUNT
    |=> sda_oe && lq.cnt == $past(lq.shreg) && lq.state == sibw_pkg::ST_DATA)
    else $error("byte count not acknowledged");

  data_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    byte_done && lq.state == sibw_pkg::ST_DATA && lq.cnt != sibw_pkg::BYTE_ZERO && !pending
    |=> lq.wr_idx == $past(lq.idx) && lq.idx == 8'($past(lq.idx) + sibw_pkg::IDX_STEP) && sda_oe)
    else $error("data byte not stored at next location");

  ack_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    scl_fall && lq.in_ack && !start_c && !stop_c |=> !sda_oe && lq.bitcnt == sibw_pkg::BIT_FIRST)
    else $error("acknowledge held past its bit");

  stop_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stop_c && !start_c |=> lq.state == sibw_pkg::ST_IDLE && !sda_oe)
    else $error("stop did not return to idle");

  addr_strap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(lq.addr_ok) |-> lq.addr == 7'(sibw_pkg::ADDR_BASE + 7'($past(lq.sel_sy[2]))) ##1 $stable(lq.addr))
    else $error("slave address not taken from select pin");

  sys_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    ce && req_edge |=> cfg_wr && cfg_wr_index == $past(lq.wr_idx))
    else $error("crossed write not applied");
endmodule
`default_nettype wire

// [logic/sibw_pkg.sv]
`default_nettype none
package sibw_pkg;
  localparam int          NUM_BYTES  = 8;
  localparam logic [6:0]  ADDR_BASE  = 7'h40;
  localparam logic [7:0]  CFG_RESET  = 8'h00;
  localparam logic [3:0]  BIT_LAST   = 4'h8;
  localparam logic [3:0]  BIT_FIRST  = 4'h0;
  localparam logic [7:0]  IDX_STEP   = 8'h01;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [6:0]  ADDR_ZERO  = 7'h00;
  localparam logic [1:0]  SEL_ZERO   = 2'h0;
  localparam logic [2:0]  SYNC_ZERO  = 3'h0;
  // strap stages seeded so no neighbours agree: latch waits for the real pin
  localparam logic [5:0]  SEL_SEED   = 6'h33;
  localparam int          SY_SECOND  = 1;
  localparam int          SY_THIRD   = 2;

  // gray steps along idle, addr, index, count, data
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_INDEX  = 3'b011,
    ST_COUNT  = 3'b010,
    ST_DATA   = 3'b110,
    ST_IGNORE = 3'b111
  } sibw_state_e;

  typedef struct packed {
    logic [2:0]      scl_sy;
    logic [2:0]      sda_sy;
    logic [2:0][1:0] sel_sy;
    logic            scl_f;
    logic            sda_f;
    sibw_state_e     state;
    logic [7:0]      shreg;
    logic [3:0]      bitcnt;
    logic            in_ack;
    logic            drive;
    logic [7:0]      idx;
    logic [7:0]      cnt;
    logic [6:0]      addr;
    logic            addr_ok;
    logic            req;
    logic [7:0]      wr_idx;
    logic [7:0]      wr_data;
    logic [2:0]      ack_sy;
  } sibw_link_s;

  typedef struct packed {
    logic [2:0]                 req_sy;
    logic [NUM_BYTES-1:0][7:0]  bytes;
    logic                       wr;
    logic [7:0]                 wr_idx;
  } sibw_sys_s;
endpackage
`default_nettype wire

// [tb/sibw_host.sv]
`timescale 1ns/10ps
`default_nettype none
// smbus host model; bit phases of 8 ref_clk keep well above the 4-cycle minimum
module sibw_host (
  input  wire logic ref_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_h
);
  initial begin
    scl   = 1'b1;
    sda_h = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // also a repeated start when scl is low
  task automatic start();
    sda_h <= 1'b1;
    tick(8);
    scl <= 1'b1;
    tick(8);
    sda_h <= 1'b0;
    tick(8);
    scl <= 1'b0;
  endtask

  task automatic stop();
    tick(4);
    sda_h <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sda_h <= 1'b1;
    tick(8);
  endtask

  // msb first, then release sda and sample the ack at scl high
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      tick(4);
      sda_h <= b[i];
      tick(4);
      scl <= 1'b1;
      tick(8);
      scl <= 1'b0;
    end
    tick(4);
    sda_h <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(4);
    ack = ~sda;
    tick(4);
    scl <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/smbus_indexed_block_write_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (a), (e)); end end
module smbus_indexed_block_write_tb;
  logic                                clock = 1'b0;
  logic                                ref_clk = 1'b0;
  logic                                rst_n = 1'b0;
  logic                                ce = 1'b1;
  logic [1:0]                          sel = 2'h0;
  logic                                scl;
  logic                                sda_h;
  logic                                sda_o;
  logic                                sda_oe;
  logic [sibw_pkg::NUM_BYTES-1:0][7:0] cfg_bytes;
  logic                                cfg_wr;
  logic [7:0]                          cfg_wr_index;
  int                                  checked = 0;
  int                                  failures = 0;
  int                                  pulses = 0;
  // open drain with pull-up: low when either party pulls
  wire                                 sda = sda_h & ~(sda_oe & ~sda_o);

  always #20 clock = ~clock;
  always #32 ref_clk = ~ref_clk;
  always @(posedge clock) if (cfg_wr === 1'b1) pulses++;

  sibw_block_write u_dut (.clock(clock), .rst_n(rst_n), .ce(ce), .ref_clk(ref_clk), .scl(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .address_select_pin(sel), .cfg_bytes(cfg_bytes), .cfg_wr(cfg_wr),
    .cfg_wr_index(cfg_wr_index));
  sibw_host u_host (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_h(sda_h));

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // reset is asynchronous, so two cycles hold both domains
  task automatic do_reset(input logic [1:0] s);
    @(posedge clock);
    rst_n <= 1'b0;
    sel   <= s;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (12) @(posedge ref_clk);
    pulses = 0;
  endtask

  // data bytes are a0, a1, ...; acks expected only for the first x
  task automatic frame(input logic [7:0] ab, input logic ok, input logic [7:0] n, input logic [7:0] x,
                       input int nd);
    logic ack;
    u_host.start();
    u_host.send_byte(ab, ack);
    `CHK(ack, ok)
    u_host.send_byte(n, ack);
    `CHK(ack, ok)
    u_host.send_byte(x, ack);
    `CHK(ack, ok)
    for (int k = 0; k < nd; k++) begin
      u_host.send_byte(8'hA0 + k[7:0], ack);
      `CHK(ack, ok & (k < int'(x)) & (ce | (k == 0)))
    end
    u_host.stop();
    repeat (20) @(posedge clock);
    `CHK(sda_oe, 1'b0)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK(cfg_bytes, '0)
    `CHK({cfg_wr, sda_oe, cfg_wr_index}, 10'h000)
    `CHK(sda_o, 1'b0)
  endtask

  // top of the array, one past it, then a surplus byte
  task automatic t_write();
    frame({7'h40, 1'b0}, 1'b1, 8'h06, 8'h03, 4);
    `CHK(cfg_bytes[6], 8'hA0)
    `CHK(cfg_bytes[7], 8'hA1)
    `CHK(cfg_bytes[0], 8'h00)
    `CHK(pulses, 3)
    `CHK(cfg_wr_index, 8'h08)
  endtask

  // then a repeated start out of an ignored transfer reaches the own address
  task automatic t_foreign();
    logic ack;
    frame({7'h41, 1'b0}, 1'b0, 8'h00, 8'h01, 1);
    frame({7'h40, 1'b1}, 1'b0, 8'h00, 8'h01, 1);
    `CHK(pulses, 3)
    `CHK(cfg_bytes[0], 8'h00)
    u_host.start();
    u_host.send_byte({7'h41, 1'b0}, ack);
    `CHK(ack, 1'b0)
    frame({7'h40, 1'b0}, 1'b1, 8'h02, 8'h01, 1);
    `CHK(cfg_bytes[2], 8'hA0)
    `CHK(pulses, 4)
  endtask

  // system side frozen: first byte waits in the crossing, the next is refused
  task automatic t_hold();
    @(posedge clock);
    ce <= 1'b0;
    frame({7'h40, 1'b0}, 1'b1, 8'h01, 8'h02, 2);
    `CHK(pulses, 4)
    `CHK(cfg_bytes[1], 8'h00)
    @(posedge clock);
    ce <= 1'b1;
    repeat (12) @(posedge clock);
    `CHK(pulses, 5)
    `CHK(cfg_bytes[1], 8'hA0)
    `CHK(cfg_bytes[2], 8'hA0)
    `CHK(cfg_wr_index, 8'h01)
  endtask

  // new strap after reset moves the address; index wraps at 8 bits
  task automatic t_strap();
    do_reset(2'h2);
    frame({7'h40, 1'b0}, 1'b0, 8'h00, 8'h01, 1);
    frame({7'h42, 1'b0}, 1'b1, 8'hFF, 8'h02, 2);
    `CHK(cfg_bytes[0], 8'hA1)
    `CHK(cfg_bytes[6], 8'h00)
    `CHK(pulses, 2)
    `CHK(cfg_wr_index, 8'h00)
  endtask

  initial begin
    do_reset(2'h0);
    t_reset();
    t_write();
    t_foreign();
    t_hold();
    t_strap();
    results();
  end

  initial begin
    #2000000;
    failures++;
    results();
  end
endmodule
`default_nettype wire
